// File: rtl/pms_pkg.sv
package pms_pkg;
    localparam logic [4:0]  REG_MMD_CTRL    = 5'h0d;
    localparam logic [4:0]  REG_MMD_DATA    = 5'h0e;
    localparam logic [4:0]  REG_IRQ         = 5'h1b;
    localparam logic [4:0]  REG_PHY_CTRL2   = 5'h1f;
    localparam int          IRQ_POL_BIT     = 14;
    localparam logic [15:0] IRQ_RESET       = 16'h0000;
    localparam logic [15:0] CTRL2_RESET     = 16'h0000;
    localparam int          PREAMBLE_LEN    = 32;
    localparam logic [1:0]  OP_READ         = 2'b10;
    localparam logic [1:0]  OP_WRITE        = 2'b01;
    localparam logic [1:0]  ADDR_TOP        = 2'b00;
    localparam logic [15:0] MMD_FN_MASK     = 16'hc000;
    localparam logic [1:0]  MMD_FN_ADDR     = 2'b00;
    localparam int          MMD_DEVS        = 32;

    typedef enum logic [2:0] {
        PMS_IDLE = 3'b000,
        PMS_HDR  = 3'b001,
        PMS_TA   = 3'b010,
        PMS_RD   = 3'b011,
        PMS_WR   = 3'b100
    } pms_state_e;
endpackage

// File: rtl/pms_mgmt_slave.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [R1] Answer only own address, strapped at reset
// [R2] Address zero is unique, never broadcast
// [R3] Controller writes each device separately
// [R4] Read frame: preamble, 01, 10, Z0, data
// [R5] Write frame: preamble, 01, 01, 10, data
// [R6] Five-bit number selects 32 registers
// [R7] Controller sources clock; single data line
// [R8] Optional interrupt output flags status changes
// [R9] Upper interrupt bits enable each condition
// [R10] Lower interrupt bits latch occurred events
// [R11] Reading interrupt register clears latched bits
// [R12] Control bit 14 sets level, reset low
// [R13] Extended registers reached via two portals
// [R14] Sample on rising, change after rising
// [R15] Interrupt holds while enabled status latched
module pms_mgmt_slave (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [2:0]  mgmt_addr_straps,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic [7:0]  irq_events,
    output logic             irq_out
);
    logic [1:0]  mdc_sync;
    logic [1:0]  mdio_sync;
    logic        mdc_prev;
    logic [2:0]  phy_addr;
    logic [5:0]  strap_sync;
    logic        strap_pending;
    pms_pkg::pms_state_e state;
    pms_pkg::pms_state_e next_state;
    logic [5:0]  cnt;
    logic [5:0]  next_cnt;
    logic [13:0] hdr;
    logic [13:0] next_hdr;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic        out_bit;
    logic        next_out_bit;
    logic        oe;
    logic        next_oe;
    logic [15:0] regs [32];
    logic [15:0] mmd_store [pms_pkg::MMD_DEVS];
    logic [4:0]  mmd_ptr;
    logic        wr_stb;
    logic        rd_stb;
    logic [4:0]  acc_reg;
    logic        rise;
    logic        mine;

    assign rise = mdc_sync[1] & ~mdc_prev; // [R14]
    // Only the address is compared; the top two bits must read 00
    assign mine = (hdr[9:8] == pms_pkg::ADDR_TOP) && (hdr[7:5] == phy_addr); // [R1] [R2]
    assign acc_reg = hdr[4:0];

    always_ff @(posedge clk) begin
        mdc_sync  <= srst ? 2'b00 : {mdc_sync[0], mdc};
        mdio_sync <= srst ? 2'b11 : {mdio_sync[0], mdio_in};
        mdc_prev  <= srst ? 1'b0 : mdc_sync[1];
        // Straps are pins: kept sampling through reset so the capture sees settled levels
        strap_sync <= {strap_sync[2:0], mgmt_addr_straps};
    end

    // Straps are caught on the first clocked edge after reset release
    always_ff @(posedge clk) begin
        if (srst) begin
            strap_pending <= 1'b1;
            phy_addr      <= 3'h0;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            phy_addr      <= strap_sync[5:3]; // [R1]
        end
    end

    function automatic logic [15:0] rd_value(input logic [4:0] a);
        if (a == pms_pkg::REG_MMD_DATA) begin
            rd_value = mmd_store[mmd_ptr]; // [R13]
        end else begin
            rd_value = regs[a]; // [R6]
        end
    endfunction

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_hdr     = hdr;
        next_shreg   = shreg;
        next_out_bit = out_bit;
        next_oe      = oe;
        wr_stb       = 1'b0;
        rd_stb       = 1'b0;
        if (rise) begin
            case (state)
                pms_pkg::PMS_IDLE: begin
                    next_oe = 1'b0;
                    if (mdio_sync[1]) begin
                        next_cnt = (cnt == 6'd63) ? cnt : cnt + 6'd1;
                    end else if (cnt >= 6'(pms_pkg::PREAMBLE_LEN)) begin
                        // First zero after preamble is start bit 0
                        next_state = pms_pkg::PMS_HDR;
                        next_cnt   = 6'd0;
                    end else begin
                        next_cnt = 6'd0;
                    end
                end
                pms_pkg::PMS_HDR: begin
                    next_hdr = {hdr[12:0], mdio_sync[1]};
                    next_cnt = cnt + 6'd1;
                    if (cnt == 6'd12) begin
                        next_cnt   = 6'd0;
                        next_state = pms_pkg::PMS_TA;
                        // Shifted header: start[12], op[11:10], addr[9:5], reg[4:0]
                        if (!hdr[11] || (hdr[10:9] != pms_pkg::OP_READ
                                         && hdr[10:9] != pms_pkg::OP_WRITE)) begin
                            next_state = pms_pkg::PMS_IDLE; // [R4]
                        end
                    end
                end
                pms_pkg::PMS_TA: begin
                    next_cnt = cnt + 6'd1;
                    if (!mine) begin
                        next_state = (hdr[11:10] == pms_pkg::OP_READ) ? pms_pkg::PMS_RD
                                                                      : pms_pkg::PMS_WR;
                        next_oe    = 1'b0;
                    end else if (hdr[11:10] == pms_pkg::OP_READ) begin
                        next_oe      = 1'b1; // [R4]
                        next_out_bit = 1'b0;
                        if (cnt == 6'd1) begin
                            // MSB must stand before the next rise samples it
                            next_shreg   = rd_value(acc_reg);
                            next_out_bit = next_shreg[15];
                            next_shreg   = {next_shreg[14:0], 1'b0};
                            rd_stb       = 1'b1;
                            next_state = pms_pkg::PMS_RD;
                            next_cnt   = 6'd0;
                        end
                    end else if (hdr[11:10] == pms_pkg::OP_WRITE) begin
                        if (cnt == 6'd1) begin
                            next_state = pms_pkg::PMS_WR; // [R5]
                            next_cnt   = 6'd0;
                        end
                    end else begin
                        next_state = pms_pkg::PMS_IDLE;
                    end
                    if (!mine) begin
                        next_cnt = 6'd0;
                    end
                end
                pms_pkg::PMS_RD: begin
                    next_out_bit = shreg[15]; // [R14]
                    next_oe      = mine;
                    next_shreg   = {shreg[14:0], 1'b0};
                    next_cnt     = cnt + 6'd1;
                    if (cnt == 6'd15) begin
                        next_oe    = 1'b0;
                        next_state = pms_pkg::PMS_IDLE;
                        next_cnt   = 6'd0;
                    end
                end
                default: begin
                    next_shreg = {shreg[14:0], mdio_sync[1]};
                    next_cnt   = cnt + 6'd1;
                    if (cnt == 6'd15) begin
                        wr_stb     = mine; // [R3]
                        next_state = pms_pkg::PMS_IDLE;
                        next_cnt   = 6'd0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state   <= pms_pkg::PMS_IDLE;
            cnt     <= 6'd0;
            hdr     <= 14'h0000;
            shreg   <= 16'h0000;
            out_bit <= 1'b0;
            oe      <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            hdr     <= next_hdr;
            shreg   <= next_shreg;
            out_bit <= next_out_bit;
            oe      <= next_oe;
        end
    end

    logic [15:0] wdata;
    logic [15:0] next_irq;
    assign wdata = {shreg[14:0], mdio_sync[1]};

    always_comb begin
        next_irq = regs[pms_pkg::REG_IRQ];
        if (rd_stb && acc_reg == pms_pkg::REG_IRQ) begin
            next_irq[7:0] = 8'h00; // [R11]
        end
        if (wr_stb && acc_reg == pms_pkg::REG_IRQ) begin
            next_irq[15:8] = wdata[15:8]; // [R9]
        end
        // Event in the clearing cycle survives
        next_irq[7:0] = next_irq[7:0] | irq_events; // [R10]
    end

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_regs
            always_ff @(posedge clk) begin
                if (srst) begin
                    regs[gi] <= (gi == pms_pkg::REG_IRQ) ? pms_pkg::IRQ_RESET
                              : (gi == pms_pkg::REG_PHY_CTRL2) ? pms_pkg::CTRL2_RESET : 16'h0000;
                end else if (gi == pms_pkg::REG_IRQ) begin
                    regs[gi] <= next_irq;
                end else if (wr_stb && acc_reg == 5'(gi)) begin
                    regs[gi] <= wdata; // [R6]
                end
            end
        end
        for (gi = 0; gi < pms_pkg::MMD_DEVS; gi++) begin : g_mmd
            always_ff @(posedge clk) begin
                if (srst) begin
                    mmd_store[gi] <= 16'h0000;
                end else if (wr_stb && acc_reg == pms_pkg::REG_MMD_DATA && mmd_ptr == 5'(gi)) begin
                    mmd_store[gi] <= wdata; // [R13]
                end
            end
        end
    endgenerate

    // Portal: function 00 selects device; data window indexes that device's slot
    always_ff @(posedge clk) begin
        if (srst) begin
            mmd_ptr <= 5'h00;
        end else if (wr_stb && acc_reg == pms_pkg::REG_MMD_CTRL
                     && wdata[15:14] == pms_pkg::MMD_FN_ADDR) begin
            mmd_ptr <= wdata[4:0]; // [R13]
        end
    end

    logic irq_active;
    assign irq_active = |(regs[pms_pkg::REG_IRQ][15:8] & regs[pms_pkg::REG_IRQ][7:0]); // [R9] [R15]

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_out <= 1'b1;
        end else begin
            irq_out <= irq_active ~^ regs[pms_pkg::REG_PHY_CTRL2][pms_pkg::IRQ_POL_BIT]; // [R8] [R12]
        end
    end

    assign mdio_out = out_bit;
    assign mdio_oe  = oe;
endmodule

`default_nettype wire

// File: testbench/pms_props.sv
`timescale 1ns/10ps
`default_nettype none
module pms_props (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [2:0] mgmt_addr_straps,
    input wire logic       mdc,
    input wire logic       mdio_in,
    input wire logic       mdio_out,
    input wire logic       mdio_oe,
    input wire logic [7:0] irq_events,
    input wire logic       irq_out
);
    logic       mdc_q;
    logic [5:0] ones, pos, span;
    logic [3:0] since;
    wire logic  rise = mdc & !mdc_q;
    // Bit position counted from the start bit rise
    always_ff @(posedge clk) begin
        mdc_q <= mdc;
        if (srst) begin
            ones  <= 6'h00;
            pos   <= 6'h3f;
            span  <= 6'h00;
            since <= 4'hf;
        end else begin
            if (rise) ones <= !mdio_in ? 6'h00 : ones + 6'(ones != 6'h3f);
            if (rise) pos <= (ones >= 6'h20 && !mdio_in) ? 6'h00 : pos + 6'(pos != 6'h3f);
            since <= rise ? 4'h0 : since + 4'(since != 4'hf);
            span  <= !mdio_oe ? 6'h00 : span + 6'(rise);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence drive_s;
        !mdio_out ##1 mdio_oe [*8];
    endsequence
    rst_idle_a: assert property (disable iff (1'b0) srst |=> !mdio_oe && irq_out)
        else $error("line driven or irq active after reset");
    ta_drive_a: assert property ($rose(mdio_oe) |-> drive_s)
        else $error("turnaround not driven low");
    oe_start_a: assert property ($rose(mdio_oe) |-> pos == 6'h0e)
        else $error("drive began at wrong bit");
    oe_window_a: assert property (mdio_oe |-> pos >= 6'h0e && pos <= 6'h1f)
        else $error("drive outside read data field");
    oe_span_a: assert property ($fell(mdio_oe) |-> span == 6'h11)
        else $error("wrong number of driven bits");
    edge_out_a: assert property (mdio_oe && $changed(mdio_out) |-> since < 4'h8)
        else $error("read data changed late");
    oe_fall_a: assert property ($fell(mdio_oe) |-> since < 4'h8)
        else $error("release not after clock rise");
    irq_cause_a: assert property ($changed(irq_out) |-> since < 4'h8 ||
        |{$past(irq_events), $past(irq_events, 2), $past(irq_events, 3)})
        else $error("irq moved without cause");
endmodule
`default_nettype wire

// File: testbench/pms_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module pms_ctrl_model (
    input  wire logic clk,
    input  wire logic line,
    output logic      mdc,
    output logic      oe,
    output logic      d
);
    logic [16:0] rd;
    // Clock parked low between frames
    initial begin
        mdc = 1'b0;
        oe = 1'b0;
        d = 1'b0;
    end
    task automatic bit_io(input logic drive, input logic b);
        @(posedge clk) oe <= drive;
        d <= b;
        repeat (7) @(posedge clk);
        rd = {rd[15:0], line};
        mdc <= 1'b1;
        repeat (8) @(posedge clk);
        mdc <= 1'b0;
    endtask
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] q, output logic ta);
        logic [13:0] hdr;
        hdr = {2'b01, op, phy, rg};
        repeat (32) bit_io(1'b1, 1'b1);
        for (int i = 13; i >= 0; i--) bit_io(1'b1, hdr[i]);
        if (op == pms_pkg::OP_WRITE) begin
            bit_io(1'b1, 1'b1);
            bit_io(1'b1, 1'b0);
            for (int i = 15; i >= 0; i--) bit_io(1'b1, wd[i]);
        end else repeat (18) bit_io(1'b0, 1'b0);
        q = rd[15:0];
        ta = rd[16];
        bit_io(1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// File: testbench/pms_mgmt_slave_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pms_mgmt_slave_tb;
    localparam logic [4:0] ME = 5'h03;
    logic        clk, srst, mdio_out, mdio_oe, irq_out, mdc, c_oe, c_d, ta;
    logic [2:0]  straps;
    logic [7:0]  ev;
    logic [4:0]  r;
    logic [4:0]  used [6];
    logic [15:0] q, a, b;
    logic [15:0] mem [32];
    int          n_fail = 0, comparisons = 0, seed = 45;
    // Pull-up holds the line high when nobody drives
    wire logic   line = mdio_oe ? mdio_out : (c_oe ? c_d : 1'b1);
    pms_mgmt_slave dut (.clk(clk), .srst(srst), .mgmt_addr_straps(straps), .mdc(mdc), .mdio_in(line),
                        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_events(ev), .irq_out(irq_out));
    pms_ctrl_model ctrl (.clk(clk), .line(line), .mdc(mdc), .oe(c_oe), .d(c_d));
    function automatic logic irq_lvl(input logic [15:0] v, input logic pol);
        return !(|(v[15:8] & v[7:0]) ^ pol);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [4:0] p, input logic [4:0] rg, input logic [15:0] d);
        ctrl.xfer(pms_pkg::OP_WRITE, p, rg, d, q, ta);
    endtask
    task automatic rd(input logic [4:0] p, input logic [4:0] rg);
        ctrl.xfer(pms_pkg::OP_READ, p, rg, 16'h0000, q, ta);
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= 8'h00;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500_000;
        n_fail++;
        complete_run();
    end
    initial begin
        srst = 1'b1;
        straps = ME[2:0];
        ev = 8'h00;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        check("oe", 16'(mdio_oe), 16'h0000);
        check("irq", 16'(irq_out), 16'(irq_lvl(16'h0000, 1'b0)));
        @(posedge clk) straps <= 3'h0;
        repeat (2) @(posedge clk);
        a = 16'($random(seed));
        b = 16'($random(seed));
        wr(ME, 5'h04, a);
        wr(5'h00, 5'h04, b);
        wr(5'h0b, 5'h04, b);
        rd(ME, 5'h04);
        check("own", q, a);
        check("ta", 16'(ta), 16'h0000);
        rd(5'h00, 5'h04);
        check("other", q, 16'hffff);
        ctrl.xfer(2'b11, ME, 5'h04, 16'h0000, q, ta);
        check("badop", q, 16'hffff);
        rd(ME, 5'h04);
        check("kept", q, a);
        for (int i = 0; i < 6; i++) begin
            r = 5'($random(seed));
            if (r inside {5'h0d, 5'h0e, 5'h1b, 5'h1f}) r ^= 5'h10;
            used[i] = r;
            mem[r] = 16'($random(seed));
            wr(ME, r, mem[r]);
        end
        for (int i = 0; i < 6; i++) begin
            rd(ME, used[i]);
            check("reg", q, mem[used[i]]);
        end
        wr(ME, pms_pkg::REG_MMD_CTRL, 16'h0002);
        wr(ME, pms_pkg::REG_MMD_DATA, a);
        wr(ME, pms_pkg::REG_MMD_CTRL, 16'h0005);
        wr(ME, pms_pkg::REG_MMD_DATA, b);
        wr(ME, pms_pkg::REG_MMD_CTRL, 16'h0002);
        rd(ME, pms_pkg::REG_MMD_DATA);
        check("mmd", q, a);
        wr(ME, pms_pkg::REG_MMD_CTRL, 16'h4005);
        rd(ME, pms_pkg::REG_MMD_DATA);
        check("mmdfn", q, a);
        wr(ME, pms_pkg::REG_IRQ, 16'h0100);
        pulse(8'h02);
        check("masked", 16'(irq_out), 16'(irq_lvl(16'h0102, 1'b0)));
        pulse(8'h01);
        check("raised", 16'(irq_out), 16'(irq_lvl(16'h0103, 1'b0)));
        rd(ME, pms_pkg::REG_IRQ);
        check("status", q, 16'h0103);
        check("cleared", 16'(irq_out), 16'(irq_lvl(16'h0100, 1'b0)));
        rd(ME, pms_pkg::REG_IRQ);
        check("reread", q, 16'h0100);
        wr(ME, pms_pkg::REG_PHY_CTRL2, 16'h4000);
        pulse(8'h01);
        check("high", 16'(irq_out), 16'(irq_lvl(16'h0101, 1'b1)));
        complete_run();
    end
endmodule
bind pms_mgmt_slave pms_props chk (.clk(clk), .srst(srst), .mgmt_addr_straps(mgmt_addr_straps), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .irq_events(irq_events), .irq_out(irq_out));
`default_nettype wire
